// ### hdl/charge_time_unit.sv
// Summary of operation
// - Unit works only while unit_on, top bit of first control, is one, except the discharge and current trim outputs.
// - With idle_stop set, unit stops operating while the device idles, except the discharge and current trim outputs.
// - delay_pulse_on enables edge delay pulse generation.
// - edge_unblock zero ignores all edges; one accepts selected edges.
// - edge_order_force: second edge accepted only after first edge.
// - source_discharge one grounds the current source output.
// - converter_trigger_on enables the converter trigger output.
// - Bit six of first control is unimplemented, reads zero.
// - second_edge_polarity one means rising, zero means falling.
// - Second source: 11 pin one, 10 pin two, 01/00 compare units.
// - first_edge_polarity one means rising, zero means falling.
// - First source field uses the same encoding as the second.
// - second_edge_seen reads one once an accepted second edge occurred.
// - first_edge_seen reads one once an accepted first edge occurred.
// - Six-bit signed trim around nominal current, zero is nominal.
// - Range: 11 hundredfold, 10 tenfold, 01 base, 00 source off.
// - All registers clear on reset; unit disabled, source off.
// - Any sleep mode forces the current source off.
//
// The implementer's own choices: the placing of the registers and register access over APB.

`include "charge_time_unit_map.svh"
`default_nettype none

module charge_time_unit
    import charge_time_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic edge_pin_one,
    input wire logic edge_pin_two,
    input wire logic compare_unit_one,
    input wire logic compare_unit_two,
    input wire logic device_idle,
    input wire logic device_sleep,
    output logic irq,
    output logic source_on,
    output logic discharge,
    output logic delay_pulse_en,
    output logic conv_trigger,
    output logic [1:0] current_range,
    output logic [5:0] current_trim,
    output logic first_edge_seen,
    output logic second_edge_seen
);

    unit_state_t s_q;
    unit_state_t s_d;

    // Pick one source by the shared encoding
    function automatic logic pick_source(input logic [1:0] sel,
                                         input logic [3:0] srcs);
        logic r;
        r = 1'b0;
        case (edge_source_t'(sel))
            SRC_PIN_ONE: r = srcs[3];
            SRC_PIN_TWO: r = srcs[2];
            SRC_COMPARE_ONE: r = srcs[1];
            SRC_COMPARE_TWO: r = srcs[0];
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick_source

    // Next-state logic
    always_comb begin
        logic [3:0] srcs;
        logic [3:0] rise;
        logic [3:0] fall;
        logic active;
        logic accept;
        logic first_hit;
        logic second_hit;
        logic second_ok;
        logic wr;
        logic rd;
        logic hit;
        logic [7:0] wbyte;
        logic [31:0] rdata;
        logic [1:0] first_sel;
        logic [1:0] second_sel;
        logic [1:0] evt;
        srcs = 4'h0;
        rise = 4'h0;
        fall = 4'h0;
        active = 1'b0;
        accept = 1'b0;
        first_hit = 1'b0;
        second_hit = 1'b0;
        second_ok = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        hit = 1'b0;
        wbyte = 8'h00;
        rdata = 32'h0000_0000;
        first_sel = 2'h0;
        second_sel = 2'h0;
        evt = 2'h0;
        s_d = s_q;

        // Pins pass two flops; compare triggers are on-clock
        s_d.pin_one_sync = {s_q.pin_one_sync[0], edge_pin_one};
        s_d.pin_two_sync = {s_q.pin_two_sync[0], edge_pin_two};
        s_d.idle_sync = {s_q.idle_sync[0], device_idle};
        s_d.sleep_sync = {s_q.sleep_sync[0], device_sleep};
        srcs = {s_q.pin_one_sync[1], s_q.pin_two_sync[1],
                compare_unit_one, compare_unit_two};
        s_d.src_prev = srcs;
        rise = srcs & ~s_q.src_prev;
        fall = ~srcs & s_q.src_prev;

        // Unit active gating
        active = s_q.ctl_high[`HI_UNIT_ON]
            & ~(s_q.ctl_high[`HI_IDLE_STOP] & s_q.idle_sync[1]);
        accept = active & s_q.ctl_high[`HI_EDGE_UNBLOCK];

        // Edge detection per polarity and source
        first_sel = s_q.ctl_low[`LO_FIRST_SRC_HI:`LO_FIRST_SRC_LO];
        second_sel = s_q.ctl_low[`LO_SECOND_SRC_HI:`LO_SECOND_SRC_LO];
        first_hit = accept & (s_q.ctl_low[`LO_FIRST_POL] ?
            pick_source(first_sel, rise) : pick_source(first_sel, fall));
        second_ok = ~s_q.ctl_high[`HI_EDGE_ORDER_FORCE]
            | s_q.ctl_low[`LO_FIRST_SEEN] | (s_q.seq != SEQ_WAIT_FIRST);
        second_hit = accept & second_ok & (s_q.ctl_low[`LO_SECOND_POL] ?
            pick_source(second_sel, rise) :
            pick_source(second_sel, fall));

        // APB decode, zero wait states
        wr = psel & penable & pwrite;
        rd = psel & ~pwrite;
        wbyte = pwdata[7:0];
        hit = (paddr == `CTL_HIGH_OFS) | (paddr == `CTL_LOW_OFS)
            | (paddr == `CUR_CTL_OFS) | (paddr == `IRQ_STATUS_OFS)
            | (paddr == `IRQ_MASK_OFS);
        s_d.pready = psel & ~penable;
        s_d.pslverr = psel & ~penable & ~hit;

        // Register writes
        if (wr & pstrb[0]) begin
            case (paddr)
                `CTL_HIGH_OFS: begin
                    s_d.ctl_high = wbyte & `HI_WRITE_MASK;
                end
                `CTL_LOW_OFS: begin
                    s_d.ctl_low = wbyte;
                end
                `CUR_CTL_OFS: begin
                    s_d.cur_ctl = wbyte;
                end
                `IRQ_STATUS_OFS: begin
                    s_d.irq_status = s_q.irq_status & ~wbyte[1:0];
                end
                `IRQ_MASK_OFS: begin
                    s_d.irq_mask = wbyte[1:0];
                end
                default: begin
                end
            endcase
        end

        // Hardware edges win over a same-cycle write
        if (first_hit) begin
            s_d.ctl_low[`LO_FIRST_SEEN] = 1'b1;
        end
        if (second_hit) begin
            s_d.ctl_low[`LO_SECOND_SEEN] = 1'b1;
        end
        evt = {second_hit, first_hit};
        s_d.irq_status = s_d.irq_status | evt;

        // Sequence tracker for ordered edges
        case (s_q.seq)
            SEQ_WAIT_FIRST: begin
                if (first_hit) begin
                    s_d.seq = SEQ_FIRST_DONE;
                end
            end
            SEQ_FIRST_DONE: begin
                if (second_hit) begin
                    s_d.seq = SEQ_BOTH_DONE;
                end
            end
            SEQ_BOTH_DONE: begin
                s_d.seq = SEQ_BOTH_DONE;
            end
            default: begin
                s_d.seq = SEQ_WAIT_FIRST;
            end
        endcase
        if (~s_d.ctl_low[`LO_FIRST_SEEN] & ~s_d.ctl_low[`LO_SECOND_SEEN]) begin
            s_d.seq = SEQ_WAIT_FIRST;
        end

        // Read mux
        case (paddr)
            `CTL_HIGH_OFS: rdata = {24'h000000, s_q.ctl_high};
            `CTL_LOW_OFS: rdata = {24'h000000, s_q.ctl_low};
            `CUR_CTL_OFS: rdata = {24'h000000, s_q.cur_ctl};
            `IRQ_STATUS_OFS: rdata = {30'h0, s_q.irq_status};
            `IRQ_MASK_OFS: rdata = {30'h0, s_q.irq_mask};
            default: rdata = 32'h0000_0000;
        endcase
        s_d.prdata = (rd & ~penable) ? rdata : 32'h0000_0000;

        // Analog controls, registered
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);
        s_d.source_on = active & ~s_q.sleep_sync[1]
            & (s_q.cur_ctl[`CUR_RANGE_HI:`CUR_RANGE_LO]
               != RANGE_OFF);
        s_d.range_out = (active & ~s_q.sleep_sync[1])
            ? s_q.cur_ctl[`CUR_RANGE_HI:`CUR_RANGE_LO] : 2'h0;
        s_d.trim_out = s_q.cur_ctl[`CUR_TRIM_HI:`CUR_TRIM_LO];
        s_d.discharge = s_q.ctl_high[`HI_SOURCE_DISCHARGE];
        s_d.delay_pulse_en = active
            & s_q.ctl_high[`HI_DELAY_PULSE_ON];
        s_d.conv_trigger = active
            & s_q.ctl_high[`HI_CONV_TRIG_ON];
        s_d.first_edge_out = active & s_q.ctl_low[`LO_FIRST_SEEN];
        s_d.second_edge_out = active & s_q.ctl_low[`LO_SECOND_SEEN];
    end

    // State register, all clear on reset except seq, which loads SEQ_WAIT_FIRST
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{ctl_high: `CTL_HIGH_RST, ctl_low: `CTL_LOW_RST,
                     cur_ctl: `CUR_CTL_RST, irq_status: `IRQ_RST,
                     irq_mask: `IRQ_RST, seq: SEQ_WAIT_FIRST,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irq = s_q.irq;
    assign source_on = s_q.source_on;
    assign discharge = s_q.discharge;
    assign delay_pulse_en = s_q.delay_pulse_en;
    assign conv_trigger = s_q.conv_trigger;
    assign current_range = s_q.range_out;
    assign current_trim = s_q.trim_out;
    assign first_edge_seen = s_q.first_edge_out;
    assign second_edge_seen = s_q.second_edge_out;

endmodule : charge_time_unit

`default_nettype wire

// ### hdl/charge_time_unit_map.svh
`ifndef CHARGE_TIME_UNIT_MAP_SVH
`define CHARGE_TIME_UNIT_MAP_SVH

// Register byte offsets
`define CTL_HIGH_OFS 12'h000
`define CTL_LOW_OFS 12'h004
`define CUR_CTL_OFS 12'h008
`define IRQ_STATUS_OFS 12'h00C
`define IRQ_MASK_OFS 12'h010

// First control register fields
`define HI_UNIT_ON 7
`define HI_IDLE_STOP 5
`define HI_DELAY_PULSE_ON 4
`define HI_EDGE_UNBLOCK 3
`define HI_EDGE_ORDER_FORCE 2
`define HI_SOURCE_DISCHARGE 1
`define HI_CONV_TRIG_ON 0
`define HI_WRITE_MASK 8'hBF

// Second control register fields
`define LO_SECOND_POL 7
`define LO_SECOND_SRC_HI 6
`define LO_SECOND_SRC_LO 5
`define LO_FIRST_POL 4
`define LO_FIRST_SRC_HI 3
`define LO_FIRST_SRC_LO 2
`define LO_SECOND_SEEN 1
`define LO_FIRST_SEEN 0

// Current control fields
`define CUR_TRIM_HI 7
`define CUR_TRIM_LO 2
`define CUR_RANGE_HI 1
`define CUR_RANGE_LO 0

// Interrupt status bits
`define IRQ_FIRST_EDGE 0
`define IRQ_SECOND_EDGE 1

// Reset values
`define CTL_HIGH_RST 8'h00
`define CTL_LOW_RST 8'h00
`define CUR_CTL_RST 8'h00
`define IRQ_RST 2'h0

`endif

// ### hdl/charge_time_unit_pkg.sv
`default_nettype none

package charge_time_unit_pkg;

    // Edge source selection codes
    typedef enum logic [1:0] {
        SRC_COMPARE_TWO = 2'h0,
        SRC_COMPARE_ONE = 2'h1,
        SRC_PIN_TWO = 2'h2,
        SRC_PIN_ONE = 2'h3
    } edge_source_t;

    // Current range codes
    typedef enum logic [1:0] {
        RANGE_OFF = 2'h0,
        RANGE_BASE = 2'h1,
        RANGE_TEN = 2'h2,
        RANGE_HUNDRED = 2'h3
    } current_range_t;

    // Edge acceptance sequence, one-hot
    typedef enum logic [2:0] {
        SEQ_WAIT_FIRST = 3'h1,
        SEQ_FIRST_DONE = 3'h2,
        SEQ_BOTH_DONE = 3'h4
    } seq_state_t;

    // All state of the unit
    typedef struct packed {
        logic [7:0] ctl_high;
        logic [7:0] ctl_low;
        logic [7:0] cur_ctl;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [1:0] pin_one_sync;
        logic [1:0] pin_two_sync;
        logic [1:0] idle_sync;
        logic [1:0] sleep_sync;
        logic [3:0] src_prev;
        seq_state_t seq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic source_on;
        logic discharge;
        logic delay_pulse_en;
        logic conv_trigger;
        logic [1:0] range_out;
        logic [5:0] trim_out;
        logic first_edge_out;
        logic second_edge_out;
    } unit_state_t;

endpackage : charge_time_unit_pkg

`default_nettype wire

// ### bench/edge_src.sv
`default_nettype none

module edge_src (
    input wire logic pclk,
    output logic pin_one,
    output logic pin_two,
    output logic cmp_one,
    output logic cmp_two
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] lvl = 4'h0;

    // Source levels, indexed by the unit's source code
    assign {pin_one, pin_two, cmp_one, cmp_two} = lvl;

    // Change one source just after an edge
    task automatic drive(input logic [1:0] sel, input logic v);
        @(posedge pclk);
        lvl[sel] <= v;
    endtask : drive
endmodule : edge_src

`default_nettype wire

// ### bench/charge_time_unit_chk.sv
`include "charge_time_unit_map.svh"
`default_nettype none

module charge_time_unit_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic device_sleep,
    input wire logic irq,
    input wire logic source_on,
    input wire logic discharge,
    input wire logic [1:0] current_range
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access cycle that writes the first control register
    wire hi_wr = psel && penable && pwrite && paddr == `CTL_HIGH_OFS;
    // Setup phase of any transfer
    wire setup_w = psel && !penable;
    sequence setup_s;
        psel && !penable;
    endsequence

    setup_ready_a: assert property (setup_s |=> pready && penable)
        else $error("no ready after setup");
    ready_phase_a: assert property (pready |-> $past(setup_w))
        else $error("ready outside access");
    addr_err_a: assert property (pready |->
        pslverr == (paddr > 12'h010 || paddr[1:0] != 2'h0))
        else $error("wrong error response");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    bit6_zero_a: assert property (
        pready && paddr == `CTL_HIGH_OFS |-> !prdata[6])
        else $error("unused bit reads one");
    reset_quiet_a: assert property (
        $rose(presetn) |-> !source_on && !irq && !discharge)
        else $error("outputs active after reset");
    sleep_off_a: assert property (
        device_sleep [*4] |-> !source_on && current_range == 2'h0)
        else $error("source on in sleep");
    range_src_a: assert property (
        source_on |-> current_range != 2'h0)
        else $error("source on with range off");
    discharge_wr_a: assert property (
        $rose(discharge) |-> $past(hi_wr) || $past(hi_wr, 2))
        else $error("discharge rose without write");
endmodule : charge_time_unit_chk

bind charge_time_unit charge_time_unit_chk u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_sleep(device_sleep), .irq(irq), .source_on(source_on),
    .discharge(discharge), .current_range(current_range));

`default_nettype wire

// ### bench/tb.sv
`include "charge_time_unit_map.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, device_idle = 1'b0, device_sleep = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, source_on, discharge, delay_pulse_en;
    logic conv_trigger, seen1, seen2, p1, p2, c1, c2;
    logic [1:0] current_range;
    logic [5:0] current_trim;
    logic [7:0] cfg;
    int miscompares = 0, check_count = 0, cycles = 0;

    charge_time_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .edge_pin_one(p1), .edge_pin_two(p2),
        .compare_unit_one(c1), .compare_unit_two(c2),
        .device_idle(device_idle), .device_sleep(device_sleep),
        .irq(irq), .source_on(source_on), .discharge(discharge),
        .delay_pulse_en(delay_pulse_en), .conv_trigger(conv_trigger),
        .current_range(current_range), .current_trim(current_trim),
        .first_edge_seen(seen1), .second_edge_seen(seen2));
    edge_src src (.pclk(pclk), .pin_one(p1), .pin_two(p2),
        .cmp_one(c1), .cmp_two(c2));

    // Clock and cycle ceiling
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    // One APB transfer; waits for ready, checks the error response
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        chk(pslverr, a > 12'h010 || a[1:0] != 2'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd

    // Main sequence
    initial begin
        wt(10);
        presetn <= 1'b1;
        for (int i = 0; i <= 16; i += 4)
            rd(12'(i), 32'h0);
        rd(12'h020, 32'h0);
        wr(`CTL_HIGH_OFS, 32'hFF);
        rd(`CTL_HIGH_OFS, 32'hBF);
        wt(3);
        chk({delay_pulse_en, discharge, conv_trigger},
            3'h7);
        device_idle <= 1'b1;
        wt(5);
        chk({delay_pulse_en, conv_trigger}, 2'h0);
        device_idle <= 1'b0;
        wr(`CTL_HIGH_OFS, 32'h8C);
        for (int r = 0; r < 4; r++) begin
            wr(`CUR_CTL_OFS, {r[0] ? 6'h1F : 6'h21, r[1:0]});
            wt(3);
            chk({source_on, current_range, current_trim, discharge},
                {r != 0, r[1:0], r[0] ? 6'h1F : 6'h21,
                1'b0});
        end
        device_sleep <= 1'b1;
        wt(5);
        chk({source_on, current_range}, 3'h0);
        device_sleep <= 1'b0;
        wr(`CTL_HIGH_OFS, 32'h0C);
        wt(5);
        chk(source_on, 1'b0);
        wr(`CTL_HIGH_OFS, 32'h8C);
        wr(`IRQ_MASK_OFS, 32'h3);
        for (int s = 0; s < 4; s++) begin
            cfg = {1'b1, s[1:0], 1'b0, s[1:0], 2'b00};
            wr(`CTL_LOW_OFS, cfg);
            src.drive(s[1:0], 1'b1);
            wt(6);
            rd(`CTL_LOW_OFS, cfg);
            src.drive(s[1:0], 1'b0);
            wt(6);
            rd(`CTL_LOW_OFS, cfg | 8'h1);
            chk({irq, seen1, seen2}, 3'h6);
            src.drive(s[1:0], 1'b1);
            wt(6);
            rd(`CTL_LOW_OFS, cfg | 8'h3);
            wr(`CTL_LOW_OFS, cfg);
            wr(`IRQ_STATUS_OFS, 32'h3);
            wt(3);
            chk({irq, seen1}, 2'h0);
        end
        wr(`IRQ_MASK_OFS, 32'h0);
        wr(`CTL_HIGH_OFS, 32'h80);
        wr(`CTL_LOW_OFS, 32'h6C);
        src.drive(2'h3, 1'b0);
        wt(6);
        rd(`CTL_LOW_OFS, 32'h6C);
        wr(`CTL_HIGH_OFS, 32'h88);
        src.drive(2'h3, 1'b1);
        src.drive(2'h3, 1'b0);
        wt(6);
        rd(`CTL_LOW_OFS, 32'h6F);
        chk(irq, 1'b0);
        wr(`IRQ_MASK_OFS, 32'h1);
        wt(3);
        chk(irq, 1'b1);
        rd(`IRQ_STATUS_OFS, 32'h3);
        wr(`IRQ_STATUS_OFS, 32'h1);
        wt(3);
        chk(irq, 1'b0);
        rd(`IRQ_STATUS_OFS, 32'h2);
        // First edge on a rising compare trigger
        wr(`CTL_LOW_OFS, 32'h14);
        src.drive(2'h1, 1'b0);
        src.drive(2'h1, 1'b1);
        wt(6);
        rd(`CTL_LOW_OFS, 32'h15);
        end_sim();
    end
endmodule : tb

`default_nettype wire
